// [rcs_device.sv]
// Purpose: receiver end of the serial config port, shifts and applies the word
// Assumes: demodulator data and window pulses come from logic on REF_CLK
// Notes:   link pins pass a two-flop synchroniser before any use
module rcs_device
  import rcs_pkg::*;
#(
  parameter int SLEEP_UNIT = rcs_pkg::SLEEP_UNIT_CYC
) (
  // clock and reset
  input  wire logic                       REF_CLK,
  input  wire logic                       SYS_RST,
  // link to host
  rcs_if.dev                              LINK,
  // demodulator side
  input  wire logic                       RX_DATA,
  input  wire logic                       WINDOW_VALID,
  input  wire logic                       WINDOW_MISS,
  // configuration view
  output logic                            CFG_VALID,
  output logic [rcs_pkg::CFG_W-1:0]       CFG_WORD,
  output logic [2:0]                      DESENSE,
  output logic [1:0]                      DEMOD_BW,
  output logic [1:0]                      SLICE_LEVEL,
  output logic [1:0]                      BIT_CHECK,
  output logic [2:0]                      WINDOW_SEL,
  output logic [2:0]                      SLEEP_SEL,
  output logic                            HIGH_BW,
  output logic                            WATCHDOG_OFF,
  output logic                            RSSI_OFFSET,
  // operating status
  output logic                            RX_ENABLE,
  output logic                            AWAKE
);
  import rcs_pkg::*;

  logic [5:0]              pins_s;
  logic                    sclk_s, data_s, pdn_s, sel_lo_s, sel_hi_s, sq_s;
  logic                    sclk_d_reg, data_d_reg;
  logic                    sclk_rise, sclk_fall, data_rise, data_fall;
  rcs_dev_state_t          st_reg, st_next;
  logic [CFG_W-1:0]        shift_reg, cfg_reg, mask;
  logic [NBIT_W-1:0]       cnt_reg;
  logic                    seen_rise_reg, commit, por_pend_reg, cfg_ok_reg;
  rcs_ap_state_t           ap_reg;
  logic [3:0]              chk_reg, chk_need;
  logic [SLEEP_CNT_W-1:0]  sleep_reg;
  logic                    autopoll;
  logic [1:0]              bw_reg;

  //////////////////////////////////////////////////////////////
  // pin synchronisers
  rcs_sync #(.W(6)) u_sync (
    .clk      (REF_CLK),
    .async_in ({LINK.sclk, LINK.data_line, LINK.power_down_pin,
                LINK.bw_select_lo, LINK.bw_select_hi, LINK.squelch_pin}),
    .sync_out (pins_s)
  );
  assign {sclk_s, data_s, pdn_s, sel_lo_s, sel_hi_s, sq_s} = pins_s;

  // edge history on synchronised levels
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      sclk_d_reg <= 1'b0;
      data_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_s;
      data_d_reg <= data_s;
    end
  end
  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign sclk_fall = ~sclk_s & sclk_d_reg;
  assign data_rise = data_s & ~data_d_reg;
  assign data_fall = ~data_s & data_d_reg;

  //////////////////////////////////////////////////////////////
  // link sequence decoder
  always_comb begin
    st_next = st_reg;
    commit  = 1'b0;
    case (st_reg)
      RCS_D_OUT:  if (sclk_s) st_next = RCS_D_REL;
      // start: clock low, high, then data pulse
      RCS_D_REL:  if (sclk_fall) st_next = RCS_D_SLO;
      RCS_D_SLO:  if (sclk_rise) st_next = RCS_D_SHI;
      RCS_D_SHI: begin
        if (sclk_fall) st_next = RCS_D_SLO;
        else if (data_rise) st_next = RCS_D_SDH;
      end
      RCS_D_SDH: begin
        if (sclk_fall) st_next = RCS_D_SLO;
        else if (data_fall) st_next = RCS_D_SHFT;
      end
      // stop: data rise then fall under high clock
      RCS_D_SHFT: begin
        if (sclk_s && data_fall && seen_rise_reg) begin
          st_next = RCS_D_END;
          commit  = 1'b1;
        end
      end
      // clock low gives the pin back
      RCS_D_END:  if (!sclk_s) st_next = RCS_D_OUT;
      default:    st_next = RCS_D_OUT;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) st_reg <= RCS_D_OUT;
    else st_reg <= st_next;
  end

  // shift MSB first on clock rise
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      shift_reg     <= '0;
      cnt_reg       <= '0;
      seen_rise_reg <= 1'b0;
    end else if (st_reg != RCS_D_SHFT) begin
      cnt_reg       <= '0;
      seen_rise_reg <= 1'b0;
    end else if (sclk_rise) begin
      shift_reg     <= {shift_reg[CFG_W-2:0], data_s};
      cnt_reg       <= (cnt_reg == NBIT_W'(CFG_W)) ? cnt_reg : cnt_reg + 1'b1;
      seen_rise_reg <= 1'b0;
    end else if (sclk_s && data_rise) begin
      seen_rise_reg <= 1'b1;
    end
  end

  // only the shifted low bits are replaced
  assign mask = {CFG_W{1'b1}} >> (NBIT_W'(CFG_W) - cnt_reg);

  // power-on load only with shutdown held high
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      cfg_reg      <= CFG_UNINIT;
      cfg_ok_reg   <= 1'b0;
      por_pend_reg <= 1'b1;
    end else if (por_pend_reg) begin
      por_pend_reg <= 1'b0;
      cfg_ok_reg   <= pdn_s;
      if (pdn_s) cfg_reg <= CFG_RESET;
    end else if (commit) begin
      // partial word lands in the low bits
      cfg_reg <= (cfg_reg & ~mask) | (shift_reg & mask);
    end
  end

  //////////////////////////////////////////////////////////////
  // autopoll duty cycle
  assign autopoll = cfg_reg[AUTOPOLL_BIT] & ~pdn_s;
  assign chk_need = 4'h1 << cfg_reg[BITCHK_LSB +: 2];

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ap_reg    <= RCS_AP_AWAKE;
      chk_reg   <= 4'h0;
      sleep_reg <= '0;
    end else if (!autopoll) begin
      ap_reg  <= RCS_AP_AWAKE;
      chk_reg <= 4'h0;
    end else begin
      case (ap_reg)
        RCS_AP_AWAKE: begin
          if (WINDOW_MISS) begin
            ap_reg    <= RCS_AP_SLEEP;
            chk_reg   <= 4'h0;
            sleep_reg <= SLEEP_CNT_W'(SLEEP_UNIT) *
                         ({{(SLEEP_CNT_W-3){1'b0}}, cfg_reg[SLEEP_LSB +: 3]} + 1'b1);
          end else if (WINDOW_VALID) begin
            if (chk_reg + 4'h1 == chk_need) ap_reg <= RCS_AP_WOKEN;
            chk_reg <= chk_reg + 4'h1;
          end
        end
        RCS_AP_SLEEP: begin
          if (sleep_reg <= 1) ap_reg <= RCS_AP_AWAKE;
          sleep_reg <= sleep_reg - 1'b1;
        end
        RCS_AP_WOKEN: ap_reg <= RCS_AP_WOKEN;
        default:      ap_reg <= RCS_AP_AWAKE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////
  // data pin drive
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      LINK.dev_data_oe <= 1'b1;
      LINK.dev_data_o  <= 1'b0;
    end else begin
      // released three cycles after the clock rise
      LINK.dev_data_oe <= (st_next == RCS_D_OUT);
      LINK.dev_data_o  <= RX_DATA & ~pdn_s & (~autopoll | (ap_reg == RCS_AP_WOKEN));
    end
  end

  // select pins high hand bandwidth to the word
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) bw_reg <= 2'b00;
    else bw_reg <= {sel_hi_s, sel_lo_s} & cfg_reg[BW_LSB +: 2];
  end

  //////////////////////////////////////////////////////////////
  // field outputs
  assign CFG_VALID    = cfg_ok_reg;
  assign CFG_WORD     = cfg_reg;
  assign DESENSE      = cfg_reg[DESENSE_LSB +: 3];
  assign DEMOD_BW     = bw_reg;
  // slice code, ones = 50 percent
  assign SLICE_LEVEL  = cfg_reg[SLICE_LSB +: 2];
  assign BIT_CHECK    = cfg_reg[BITCHK_LSB +: 2];
  assign WINDOW_SEL   = cfg_reg[WINDOW_LSB +: 3];
  assign SLEEP_SEL    = cfg_reg[SLEEP_LSB +: 3];
  assign HIGH_BW      = cfg_reg[HIGH_BW_BIT];
  // watchdog off bit; fixed bit not decoded
  assign WATCHDOG_OFF = cfg_reg[WDOG_OFF_BIT];
  assign RSSI_OFFSET  = cfg_reg[RSSI_OFS_BIT];
  assign RX_ENABLE    = ~pdn_s & cfg_ok_reg;
  assign AWAKE        = ~pdn_s & cfg_ok_reg & (~autopoll | (ap_reg != RCS_AP_SLEEP));
endmodule

// [rcs_pkg.sv]
// Purpose: shared constants and types for the receiver serial config port
// Assumes: 100 MHz reference clock on both ends
// Notes:   field positions index the 20-bit configuration word
package rcs_pkg;
  // word layout
  localparam int CFG_W          = 20;
  localparam int NBIT_W         = 5;
  localparam int DESENSE_LSB    = 0;   // 3 bits, zero = off
  localparam int BW_LSB         = 3;   // 2 bits, zero = 1712 Hz
  localparam int SLICE_LSB      = 5;   // 2 bits, ones = 50 %
  localparam int BITCHK_LSB     = 7;   // 2 bits
  localparam int WINDOW_LSB     = 9;   // 3 bits
  localparam int SLEEP_LSB      = 12;  // 3 bits
  localparam int AUTOPOLL_BIT   = 15;
  localparam int HIGH_BW_BIT    = 16;
  localparam int FIXED_ZERO_BIT = 17;
  localparam int WDOG_OFF_BIT   = 18;
  localparam int RSSI_OFS_BIT   = 19;
  localparam logic [CFG_W-1:0] CFG_RESET   = 20'h00000;
  localparam logic [CFG_W-1:0] CFG_UNINIT  = 20'hfffff;
  // timing
  localparam int REF_MHZ        = 100;
  localparam int T_EDGE_MIN_NS  = 100;  // least interval between link edges
  localparam int T_RELEASE_NS   = 100;  // longest clock-high to release
  localparam int T_RELEASE_CYC  = T_RELEASE_NS * REF_MHZ / 1000;
  localparam int T_HALF_CYC     = (T_EDGE_MIN_NS * REF_MHZ + 999) / 1000 + 1;
  localparam int SLEEP_UNIT_MS  = 32;   // sleep step, code 4 gives 160 ms
  localparam int SLEEP_UNIT_CYC = SLEEP_UNIT_MS * 1000 * REF_MHZ;
  localparam int SLEEP_CNT_W    = 26;
  // device link states
  typedef enum logic [2:0] {
    RCS_D_OUT  = 3'b000,
    RCS_D_REL  = 3'b001,
    RCS_D_SLO  = 3'b010,
    RCS_D_SHI  = 3'b011,
    RCS_D_SDH  = 3'b100,
    RCS_D_SHFT = 3'b101,
    RCS_D_END  = 3'b110
  } rcs_dev_state_t;
  // autopoll states
  typedef enum logic [1:0] {
    RCS_AP_AWAKE = 2'b00,
    RCS_AP_SLEEP = 2'b01,
    RCS_AP_WOKEN = 2'b10
  } rcs_ap_state_t;
  // host sequencer states
  typedef enum logic [3:0] {
    RCS_H_IDLE = 4'h0,
    RCS_H_REL  = 4'h1,
    RCS_H_SLO  = 4'h2,
    RCS_H_SHI  = 4'h3,
    RCS_H_SDH  = 4'h4,
    RCS_H_SDL  = 4'h5,
    RCS_H_BLO  = 4'h6,
    RCS_H_BHI  = 4'h7,
    RCS_H_PDL  = 4'h8,
    RCS_H_PDH  = 4'h9,
    RCS_H_PDL2 = 4'ha,
    RCS_H_PCLO = 4'hb
  } rcs_host_state_t;
endpackage

// [rcs_if.sv]
// Purpose: link between host and receiver: clock, shared data pin, straps
// Assumes: data pin pulled low when nobody drives it
// Notes:   host drives the clock and the static control pins
interface rcs_if;
  logic sclk;
  logic host_data_o;
  logic host_data_oe;
  logic dev_data_o;
  logic dev_data_oe;
  logic data_line;
  logic power_down_pin;
  logic bw_select_lo;
  logic bw_select_hi;
  logic squelch_pin;
  // resolved level of the shared data wire
  assign data_line = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : 1'b0);
  modport dev (
    input  sclk, data_line, power_down_pin, bw_select_lo, bw_select_hi, squelch_pin,
    output dev_data_o, dev_data_oe
  );
  modport host (
    output sclk, host_data_o, host_data_oe, power_down_pin, bw_select_lo, bw_select_hi,
    output squelch_pin,
    input  data_line
  );
endinterface

// [rcs_sync.sv]
// Purpose: two-stage synchroniser, one per bit
// Assumes: inputs are asynchronous levels
// Notes:   first stage feeds only the second stage; no reset, so a level
//          held on the pin during reset is already through at release
module rcs_sync #(
  parameter int W = 1
) (
  // clock
  input  wire logic         clk,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;
  //////////////////////////////////////////////////////////////
  // per-bit double flop, free running so power-on sees the true pin
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk) begin
      meta_reg[i] <= async_in[i];
      sync_out[i] <= meta_reg[i];
    end
  end
endmodule

// [rcs_host.sv]
// Purpose: host end, drives start, data bits and stop on the link
// Assumes: CMD_NBITS in 1..20, word right-aligned
// Notes:   every link edge is spaced T_HALF_CYC reference cycles apart
module rcs_host
  import rcs_pkg::*;
(
  // clock and reset
  input  wire logic                       REF_CLK,
  input  wire logic                       SYS_RST,
  // link to receiver
  rcs_if.host                             LINK,
  // command side
  input  wire logic                       CMD_START,
  input  wire logic [rcs_pkg::CFG_W-1:0]  CMD_WORD,
  input  wire logic [rcs_pkg::NBIT_W-1:0] CMD_NBITS,
  input  wire logic                       POWER_DOWN,
  output logic                            BUSY,
  output logic                            DONE,
  output logic                            RX_DATA
);
  import rcs_pkg::*;

  rcs_host_state_t   st_reg;
  logic [7:0]        tmr_reg;
  logic [CFG_W-1:0]  word_reg;
  logic [NBIT_W-1:0] idx_reg;
  logic              step;

  //////////////////////////////////////////////////////////////
  // receive data view
  rcs_sync #(.W(1)) u_sync (
    .clk      (REF_CLK),
    .async_in (LINK.data_line),
    .sync_out (RX_DATA)
  );

  // start in shutdown, then follow the user
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      LINK.power_down_pin <= 1'b1;
      LINK.bw_select_lo   <= 1'b1;
      LINK.bw_select_hi   <= 1'b1;
      LINK.squelch_pin    <= 1'b1;
    end else begin
      LINK.power_down_pin <= POWER_DOWN;
    end
  end

  // every phase lasts the interval timer
  assign step = (tmr_reg == 8'(T_HALF_CYC - 1));
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || st_reg == RCS_H_IDLE || step) tmr_reg <= 8'h00;
    else tmr_reg <= tmr_reg + 8'h01;
  end

  //////////////////////////////////////////////////////////////
  // link sequencer
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      st_reg            <= RCS_H_IDLE;
      LINK.sclk         <= 1'b0;
      LINK.host_data_o  <= 1'b0;
      LINK.host_data_oe <= 1'b0;
      word_reg          <= '0;
      idx_reg           <= '0;
      DONE              <= 1'b0;
    end else begin
      DONE <= 1'b0;
      if (st_reg == RCS_H_IDLE) begin
        if (CMD_START) begin
          word_reg  <= CMD_WORD;
          idx_reg   <= CMD_NBITS - 1'b1;
          // clock high first, receiver lets go
          LINK.sclk <= 1'b1;
          st_reg    <= RCS_H_REL;
        end
      end else if (step) begin
        case (st_reg)
          // start: clock low/high at data low, then data pulse
          RCS_H_REL: begin
            LINK.sclk         <= 1'b0;
            LINK.host_data_oe <= 1'b1;
            LINK.host_data_o  <= 1'b0;
            st_reg            <= RCS_H_SLO;
          end
          RCS_H_SLO: begin
            LINK.sclk <= 1'b1;
            st_reg    <= RCS_H_SHI;
          end
          RCS_H_SHI: begin
            LINK.host_data_o <= 1'b1;
            st_reg           <= RCS_H_SDH;
          end
          RCS_H_SDH: begin
            LINK.host_data_o <= 1'b0;
            st_reg           <= RCS_H_SDL;
          end
          // bit set in the low phase, MSB first
          RCS_H_SDL, RCS_H_BHI: begin
            if (st_reg == RCS_H_BHI && idx_reg == '0) begin
              LINK.host_data_o <= 1'b0;
              st_reg           <= RCS_H_PDL;
            end else begin
              if (st_reg == RCS_H_BHI) idx_reg <= idx_reg - 1'b1;
              LINK.sclk        <= 1'b0;
              LINK.host_data_o <= word_reg[(st_reg == RCS_H_BHI) ? idx_reg - 1'b1 : idx_reg];
              st_reg           <= RCS_H_BLO;
            end
          end
          RCS_H_BLO: begin
            LINK.sclk <= 1'b1;
            st_reg    <= RCS_H_BHI;
          end
          // stop after D0: data up, down, clock low
          RCS_H_PDL: begin
            LINK.host_data_o <= 1'b1;
            st_reg           <= RCS_H_PDH;
          end
          RCS_H_PDH: begin
            LINK.host_data_o <= 1'b0;
            st_reg           <= RCS_H_PDL2;
          end
          RCS_H_PDL2: begin
            LINK.sclk         <= 1'b0;
            LINK.host_data_oe <= 1'b0;
            st_reg            <= RCS_H_PCLO;
          end
          RCS_H_PCLO: begin
            DONE   <= 1'b1;
            st_reg <= RCS_H_IDLE;
          end
          default: st_reg <= RCS_H_IDLE;
        endcase
      end
    end
  end

  assign BUSY = (st_reg != RCS_H_IDLE);
endmodule

// [rcs_assertions.sv]
// Purpose: link checks between the host end and the receiver end
// Assumes: one REF_CLK domain, SYS_RST synchronous active high
// Notes:   sees only the shared interface signals
module rcs_assertions (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // link pins
  input wire logic sclk,
  input wire logic host_data_o,
  input wire logic host_data_oe,
  input wire logic dev_data_o,
  input wire logic dev_data_oe,
  input wire logic power_down_pin,
  input wire logic bw_select_lo,
  input wire logic bw_select_hi,
  input wire logic squelch_pin
);
  logic [2:0] lnk;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);

  // host-driven pins as one vector
  assign lnk = {sclk, host_data_o, host_data_oe};

  ////////////////////////////////////////////////////////////
  // opening: clock low, clock high, data pulse with clock high
  sequence open_s;
    !sclk && !host_data_o ##[10:12] ($rose(sclk) && !host_data_o)
      ##[10:12] (sclk && $rose(host_data_o)) ##[10:12] (sclk && $fell(host_data_o));
  endsequence
  // no link edge for ten cycles
  sequence hold_s;
    $stable(lnk) [*5] ##1 $stable(lnk) [*5];
  endsequence

  ////////////////////////////////////////////////////////////
  release_on_clock_a: assert property ($rose(sclk) |-> ##[1:10] !dev_data_oe)
    else $error("data pin not released after clock rise");
  released_high_a: assert property (sclk [*8] |-> !dev_data_oe)
    else $error("data pin driven while clock high");
  no_contention_a: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive the data pin");
  open_order_a: assert property ($rose(host_data_oe) |-> open_s)
    else $error("opening sequence out of order");
  close_order_a: assert property ($fell(host_data_oe) |-> $fell(sclk) && !$past(host_data_o, 11)
    && $past(host_data_o, 12) && $past(sclk, 12))
    else $error("closing sequence out of order");
  output_return_a: assert property ($fell(sclk) && !host_data_oe |-> ##[1:10] dev_data_oe)
    else $error("data pin not returned to output");
  session_quiet_a: assert property ($rose(host_data_oe) |-> !dev_data_oe until !host_data_oe)
    else $error("device drove data inside a session");
  session_bound_a: assert property ($rose(host_data_oe) |-> ##[1:600] !host_data_oe)
    else $error("session never closed");
  edge_spacing_a: assert property ($changed(lnk) |=> hold_s)
    else $error("link edges too close");
  straps_high_a: assert property (bw_select_lo && bw_select_hi && squelch_pin)
    else $error("select or squelch pin low");
  idle_low_a: assert property (power_down_pin && $past(power_down_pin, 5) && dev_data_oe |-> !dev_data_o)
    else $error("data output active in shutdown");
endmodule

// [test_receiver_config_serial_port.sv]
// Purpose: host and receiver ends joined, checked end to end
// Assumes: SLEEP_UNIT shortened to 20 cycles
// Notes:   second receiver faces a bench host that skips the stop
module test_receiver_config_serial_port import rcs_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [CFG_W-1:0] word; int nbits;} rcs_note_t;
  logic              clk = 1'h0, rst = 1'h1, cmd_start = 1'h0, power_down = 1'h1;
  logic              rx_data = 1'h0, win_valid = 1'h0, win_miss = 1'h0;
  logic [CFG_W-1:0]  cmd_word = 20'h00000;
  logic [NBIT_W-1:0] cmd_nbits = 5'h01;
  logic              busy, done, host_rx, cfg_valid, hi_bw, wd_off, rssi_ofs, rx_en, awake;
  logic [CFG_W-1:0]  cfg_word, cfg_word2, model, shreg, msk, w;
  logic [2:0]        desense, window_sel, sleep_sel;
  logic [1:0]        demod_bw, slice, bit_chk;
  logic [31:0]       rng = 32'h0000b901;
  int                mismatches, checked, cyc, take_cyc, rises;
  rcs_note_t         notes[$];
  rcs_note_t         note;

  ////////////////////////////////////////////////////////////
  rcs_if link ();
  rcs_if link2 ();
  rcs_host u_rcs_host (.REF_CLK(clk), .SYS_RST(rst), .LINK(link), .CMD_START(cmd_start), .CMD_WORD(cmd_word),
    .CMD_NBITS(cmd_nbits), .POWER_DOWN(power_down), .BUSY(busy), .DONE(done), .RX_DATA(host_rx));
  rcs_device #(.SLEEP_UNIT(20)) u_rcs_device (.REF_CLK(clk), .SYS_RST(rst), .LINK(link), .RX_DATA(rx_data),
    .WINDOW_VALID(win_valid), .WINDOW_MISS(win_miss), .CFG_VALID(cfg_valid), .CFG_WORD(cfg_word),
    .DESENSE(desense), .DEMOD_BW(demod_bw), .SLICE_LEVEL(slice), .BIT_CHECK(bit_chk), .WINDOW_SEL(window_sel),
    .SLEEP_SEL(sleep_sel), .HIGH_BW(hi_bw), .WATCHDOG_OFF(wd_off), .RSSI_OFFSET(rssi_ofs), .RX_ENABLE(rx_en),
    .AWAKE(awake));
  rcs_device #(.SLEEP_UNIT(20)) u_rcs_device_b (.REF_CLK(clk), .SYS_RST(rst), .LINK(link2), .RX_DATA(1'h0),
    .WINDOW_VALID(1'h0), .WINDOW_MISS(1'h0), .CFG_VALID(), .CFG_WORD(cfg_word2), .DESENSE(), .DEMOD_BW(),
    .SLICE_LEVEL(), .BIT_CHECK(), .WINDOW_SEL(), .SLEEP_SEL(), .HIGH_BW(), .WATCHDOG_OFF(), .RSSI_OFFSET(),
    .RX_ENABLE(), .AWAKE());
  rcs_assertions u_rcs_assertions (.REF_CLK(clk), .SYS_RST(rst), .sclk(link.sclk), .host_data_o(link.host_data_o),
    .host_data_oe(link.host_data_oe), .dev_data_o(link.dev_data_o), .dev_data_oe(link.dev_data_oe),
    .power_down_pin(link.power_down_pin), .bw_select_lo(link.bw_select_lo), .bw_select_hi(link.bw_select_hi),
    .squelch_pin(link.squelch_pin));

  ////////////////////////////////////////////////////////////
  // clock
  always #5 clk = ~clk;

  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  // wait for the host to go idle, aligned just after an edge
  task automatic idle();
    while (busy !== 1'h0) begin
      @(posedge clk);
      #1;
    end
  endtask

  // one command, expected word noted before it starts
  task automatic send(input logic [CFG_W-1:0] wd, input int n);
    logic [CFG_W-1:0] m;
    m = (20'h00001 << n) - 20'h00001;
    model = (model & ~m) | (wd & m);
    notes.push_back('{model, n});
    idle();
    cmd_start = 1'h1;
    cmd_word = wd;
    cmd_nbits = n[NBIT_W-1:0];
    @(posedge clk);
    #1;
    cmd_start = 1'h0;
  endtask

  // bench host on the second link: opens, shifts two bits, drops clock without a stop
  task automatic fault_session();
    logic [2:0] steps [10] = '{3'h4, 3'h2, 3'h6, 3'h7, 3'h6, 3'h3, 3'h7, 3'h2, 3'h6, 3'h0};
    foreach (steps[i]) begin
      {link2.sclk, link2.host_data_oe, link2.host_data_o} = steps[i];
      repeat (T_HALF_CYC) @(posedge clk);
      #1;
    end
    check("word without stop", cfg_word2, CFG_RESET);
    check("pin after aborted session", link2.dev_data_oe, 1'h0);
  endtask

  ////////////////////////////////////////////////////////////
  // cycle count and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      mismatches++;
      complete_run();
    end
  end

  // bits on the wire, one per clock rise
  always @(posedge link.sclk) begin
    shreg = {shreg[CFG_W-2:0], link.data_line};
    rises++;
  end

  // session monitor: takes the oldest note at each done pulse
  always @(posedge clk) begin
    #2;
    // a done and the next take can share one cycle: score first
    if (done === 1'h1) begin
      note = notes.pop_front();
      w = note.word;
      msk = (20'h00001 << note.nbits) - 20'h00001;
      check("word", cfg_word, w);
      check("fields", {desense, demod_bw, slice, bit_chk, window_sel, sleep_sel, hi_bw, wd_off, rssi_ofs},
        {w[DESENSE_LSB+:3], w[BW_LSB+:2], w[SLICE_LSB+:2], w[BITCHK_LSB+:2], w[WINDOW_LSB+:3],
         w[SLEEP_LSB+:3], w[HIGH_BW_BIT], w[WDOG_OFF_BIT], w[RSSI_OFS_BIT]});
      check("latency", cyc - take_cyc, T_HALF_CYC * (9 + 2 * note.nbits));
      check("clock rises", rises, note.nbits + 2);
      check("bit order", shreg & msk, w & msk);
    end
    if (cmd_start === 1'h1 && busy === 1'h0) begin
      take_cyc = cyc + 1;
      rises = 0;
    end
  end

  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {link2.sclk, link2.host_data_oe, link2.host_data_o} = 3'h0;
    {link2.power_down_pin, link2.bw_select_lo, link2.bw_select_hi, link2.squelch_pin} = 4'hf;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'h0;
    @(posedge clk);
    #1;
    check("power-on load", {cfg_valid, cfg_word}, {1'h1, CFG_RESET});
    check("shutdown", rx_en, 1'h0);
    model = CFG_RESET;
    fault_session();
    send(20'h4c760, 20);
    send(20'h00005, 3);
    for (int i = 0; i < 8; i++) begin
      rng = xs(rng);
      send(rng[CFG_W-1:0], 1 + rng[27:20] % 20);
    end
    send(20'h4c760, 20);
    idle();
    power_down = 1'h0;
    repeat (6) @(posedge clk);
    #1;
    check("awake", {rx_en, awake, link.dev_data_o}, 3'h6);
    rx_data = 1'h1;
    // two windows, a miss, then four fresh windows to wake
    for (int i = 0; i < 6; i++) begin
      check("not woken", link.dev_data_o, 1'h0);
      win_valid = 1'h1;
      @(posedge clk);
      #1;
      win_valid = 1'h0;
      @(posedge clk);
      #1;
      if (i == 1) begin
        win_miss = 1'h1;
        @(posedge clk);
        #1;
        win_miss = 1'h0;
        repeat (90) @(posedge clk);
        #1;
        check("asleep", awake, 1'h0);
        repeat (20) @(posedge clk);
        #1;
        check("awake again", awake, 1'h1);
      end
    end
    repeat (6) @(posedge clk);
    #1;
    check("woken data", {link.dev_data_o, host_rx}, 2'h3);
    power_down = 1'h1;
    repeat (6) @(posedge clk);
    #1;
    check("shut down again", {rx_en, link.dev_data_o}, 2'h0);
    check("notes left", notes.size(), 0);
    complete_run();
  end
endmodule
